// ---- hw/ldscd_top.sv ----
// serial command front end of a 16-channel pwm led driver, with axi4-lite status access
// assumes serial clock, data, transfer line, pwm clock and fault inputs are asynchronous
// and slow against i_ref_clk (each level held several clock periods)
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps

// Operation
// - words shift in; pulse count selects command
// - count 0 or 1 loads first stage
// - count 2 or 3 latches, loads faults, starts
// - count 7 or 8 captures on/off mask
// - count 9 or 10 runs manual fault check
// - count 11 or 12 resets pwm counter
// - count 13 or 14 latches state word one
// - count 15 or 16 latches state word two
// - other counts run no command, only record the count and flag an ignored event
// - fault detection only when configured active
// - state word one picks resolution, 16-bit default
// - 16-bit on-time n, duty n/65535, default zero
// - 14-bit ignores top two bits, n/16383
// - words travel most significant bit first
// - option zero: serial out shows previous contents
// - one reference period is minimum pulse
// - repeat mode runs until counter reset
module ldscd_top (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // serial link pins
    input wire logic i_serial_data_in,
    input wire logic i_serial_clock,
    input wire logic i_transfer_command_line,
    input wire logic i_grayscale_reference_clock,
    output logic o_serial_data_out,
    // channel side
    input wire logic [15:0] i_open_load_detect,
    input wire logic [15:0] i_shorted_load_detect,
    output logic [15:0] o_channel_on,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // count-to-command decode, shared by the executor and the ignored-event flag
    function automatic ldscd_pkg::ldscd_cmd_e cmd_of(input logic [4:0] cnt);
        ldscd_pkg::ldscd_cmd_e c;
        c = ldscd_pkg::CMD_NONE;
        case (cnt)
            5'h00, 5'h01: c = ldscd_pkg::CMD_LOAD_FIRST_STAGE;
            5'h02, 5'h03: c = ldscd_pkg::CMD_LATCH_AND_START;
            5'h07, 5'h08: c = ldscd_pkg::CMD_LOAD_ON_OFF_MASK;
            5'h09, 5'h0A: c = ldscd_pkg::CMD_MANUAL_FAULT_CHECK;
            5'h0B, 5'h0C: c = ldscd_pkg::CMD_COUNTER_RESET;
            5'h0D, 5'h0E: c = ldscd_pkg::CMD_STATE_WORD_ONE;
            5'h0F, 5'h10: c = ldscd_pkg::CMD_STATE_WORD_TWO;
            default: c = ldscd_pkg::CMD_NONE;
        endcase
        return c;
    endfunction
    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = val[8*b +: 8];
            end
        end
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second
    ldscd_pkg::ldscd_pins_s pins_meta_q;
    ldscd_pkg::ldscd_pins_s pins_q;
    ldscd_pkg::ldscd_pins_s pins_prev_q;
    logic [31:0] fault_meta_q;
    logic [31:0] fault_q;
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pins_meta_q <= '0;
            pins_q <= '0;
            pins_prev_q <= '0;
            fault_meta_q <= 32'h0000_0000;
            fault_q <= 32'h0000_0000;
        end else begin
            pins_meta_q <= {i_serial_clock, i_serial_data_in, i_transfer_command_line,
                            i_grayscale_reference_clock};
            pins_q <= pins_meta_q;
            pins_prev_q <= pins_q;
            fault_meta_q <= {i_open_load_detect, i_shorted_load_detect};
            fault_q <= fault_meta_q;
        end
    end
    wire sck_rise = pins_q.sck && !pins_prev_q.sck;
    wire transfer_command_line_rise = pins_q.transfer_command_line && !pins_prev_q.transfer_command_line;
    wire transfer_command_line_fall = !pins_q.transfer_command_line && pins_prev_q.transfer_command_line;
    wire pwm_tick = pins_q.pwm_clk && !pins_prev_q.pwm_clk;
    // a channel reports a fault when its load is open or shorted
    wire [15:0] fault_word = fault_q[31:16] | fault_q[15:0];
    ////////////////////////////////////////////////////////////////////////////////
    // serial shift register and pulse counter
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    logic [4:0] pulse_cnt_q;
    logic [4:0] last_cnt_q;
    logic [15:0] result_q;
    logic result_pend_q;
    logic serial_data_out_q;
    logic [15:0] state_one_q;
    logic [15:0] state_two_q;
    logic [15:0] mask_q;
    ldscd_pkg::ldscd_state_two_s st2;
    assign st2 = state_two_q;
    wire ldscd_pkg::ldscd_cmd_e cmd = cmd_of(pulse_cnt_q);
    wire do_cmd = transfer_command_line_fall;
    wire detect_on = st2.detect;
    wire is_fault_cmd = (cmd == ldscd_pkg::CMD_LATCH_AND_START) ||
                        (cmd == ldscd_pkg::CMD_MANUAL_FAULT_CHECK);
    wire load_result = do_cmd && is_fault_cmd && detect_on;
    // the first clock after a fault load carries the result, not serial data
    wire shift_en = sck_rise && !pins_q.transfer_command_line && !result_pend_q;
    wire result_edge = sck_rise && !pins_q.transfer_command_line && result_pend_q;
    always_comb begin
        shift_d = shift_q;
        // msb first into bit 0 side
        if (shift_en) begin
            shift_d = {shift_q[14:0], pins_q.serial_data_in};
        end else if (result_edge) begin
            shift_d = result_q;
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            shift_q <= 16'h0000;
            pulse_cnt_q <= 5'h00;
            last_cnt_q <= 5'h00;
            serial_data_out_q <= 1'b0;
        end else begin
            // shift data, count pulses in transfer
            shift_q <= shift_d;
            // clear on rise, count while high
            if (transfer_command_line_rise) begin
                pulse_cnt_q <= 5'h00;
            end else if (pins_q.transfer_command_line && sck_rise && pulse_cnt_q != ldscd_pkg::CNT_MAX) begin
                pulse_cnt_q <= pulse_cnt_q + 5'h01;
            end
            if (do_cmd) begin
                last_cnt_q <= pulse_cnt_q;
            end
            serial_data_out_q <= st2.serial_data_out_opt ? 1'b0 : shift_d[15];
        end
    end
    assign o_serial_data_out = serial_data_out_q;
    // automatic result queued; manual result queued
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            result_q <= 16'h0000;
            result_pend_q <= 1'b0;
        end else if (load_result) begin
            result_q <= fault_word;
            result_pend_q <= 1'b1;
        end else if (result_edge) begin
            result_pend_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // command execution on transfer fall
    // unknown counts only record the count and raise the ignored-event flag
    wire ignored = do_cmd && (cmd == ldscd_pkg::CMD_NONE);
    wire load_word = do_cmd && (cmd == ldscd_pkg::CMD_LOAD_FIRST_STAGE);
    wire start_pwm = do_cmd && (cmd == ldscd_pkg::CMD_LATCH_AND_START);
    wire cnt_reset = do_cmd && (cmd == ldscd_pkg::CMD_COUNTER_RESET);
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            mask_q <= ldscd_pkg::MASK_RST;
            state_one_q <= ldscd_pkg::STATE_ONE_RST;
            state_two_q <= ldscd_pkg::STATE_TWO_RST;
        end else if (do_cmd) begin
            case (cmd)
                ldscd_pkg::CMD_LOAD_ON_OFF_MASK: mask_q <= shift_q;
                ldscd_pkg::CMD_STATE_WORD_ONE: state_one_q <= shift_q;
                ldscd_pkg::CMD_STATE_WORD_TWO: state_two_q <= shift_q;
                default: mask_q <= mask_q;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // grayscale stages and pwm outputs
    // resolution from state word one
    wire res14 = state_one_q[ldscd_pkg::S1_RES14_BIT];
    wire [15:0] period = res14 ? ldscd_pkg::PERIOD_14 : ldscd_pkg::PERIOD_16;
    logic [15:0] pwm_cnt_q;
    logic running_q;
    logic blank_q;
    wire period_end = running_q && pwm_tick && (pwm_cnt_q == period - 16'h0001);
    logic [15:0] stage1_q [ldscd_pkg::CHANNELS];
    logic [15:0] stage2_q [ldscd_pkg::CHANNELS];
    logic [15:0] chan_q;
    genvar ch;
    generate
        for (ch = 0; ch < ldscd_pkg::CHANNELS; ch++) begin : g_chan
            // top two bits dropped in 14-bit mode
            wire [15:0] level = res14 ? (stage2_q[ch] & ldscd_pkg::MASK_14) : stage2_q[ch];
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    stage1_q[ch] <= ldscd_pkg::GRAY_RST;
                    stage2_q[ch] <= ldscd_pkg::GRAY_RST;
                    chan_q[ch] <= 1'b0;
                end else begin
                    // chain puts the first word at channel 15
                    if (load_word) begin
                        stage1_q[ch] <= (ch == 0) ? shift_q : stage1_q[(ch + 15) % 16];
                    end
                    // first stage to second, then run
                    if (start_pwm) begin
                        stage2_q[ch] <= stage1_q[ch];
                    end
                    chan_q[ch] <= running_q && !blank_q && mask_q[ch] && (pwm_cnt_q < level);
                end
            end
        end
    endgenerate
    assign o_channel_on = chan_q;
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pwm_cnt_q <= 16'h0000;
            running_q <= 1'b0;
        end else if (cnt_reset) begin
            pwm_cnt_q <= 16'h0000;
            running_q <= 1'b0;
        end else if (start_pwm) begin
            pwm_cnt_q <= 16'h0000;
            running_q <= 1'b1;
        end else if (running_q && pwm_tick) begin
            if (period_end) begin
                pwm_cnt_q <= 16'h0000;
                running_q <= !st2.oneshot;
            end else begin
                pwm_cnt_q <= pwm_cnt_q + 16'h0001;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over a simultaneous clear
    logic [4:0] irq_stat_q;
    logic [4:0] irq_en_q;
    logic [4:0] irq_clr;
    wire [4:0] irq_set = {period_end, ignored, load_result && (fault_word != 16'h0000),
                          start_pwm, load_word};
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_stat_q <= 5'h00;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end
    assign o_irq = |(irq_stat_q & irq_en_q);
    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: one write and one read at a time, either channel order
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] ctrl_q;
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    wire wr_go = aw_have_q && w_have_q && !bvalid_q;
    wire wr_ctrl = wr_go && (aw_addr_q == ldscd_pkg::ADDR_CTRL);
    wire wr_en = wr_go && (aw_addr_q == ldscd_pkg::ADDR_IRQ_ENABLE);
    wire wr_clr = wr_go && (aw_addr_q == ldscd_pkg::ADDR_IRQ_CLEAR);
    wire wr_hit = wr_ctrl || wr_en || wr_clr;
    wire [31:0] clr_word = merge(32'h0000_0000, w_data_q, w_strb_q);
    wire [31:0] en_word = merge({27'h0, irq_en_q}, w_data_q, w_strb_q);
    assign irq_clr = wr_clr ? clr_word[4:0] : 5'h00;
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= ldscd_pkg::RESP_OKAY;
            ctrl_q <= ldscd_pkg::CTRL_RST;
            irq_en_q <= ldscd_pkg::IRQ_EN_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? ldscd_pkg::RESP_OKAY : ldscd_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_0001;
            end
            if (wr_en) begin
                irq_en_q <= en_word[4:0];
            end
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            blank_q <= 1'b0;
        end else begin
            blank_q <= ctrl_q[ldscd_pkg::CTRL_BLANK_BIT];
        end
    end
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'h0})
            ldscd_pkg::ADDR_CTRL: rd_word = ctrl_q;
            ldscd_pkg::ADDR_IRQ_STATUS: rd_word = {27'h0, irq_stat_q};
            ldscd_pkg::ADDR_IRQ_ENABLE: rd_word = {27'h0, irq_en_q};
            ldscd_pkg::ADDR_STATE_ONE: rd_word = {16'h0, state_one_q};
            ldscd_pkg::ADDR_STATE_TWO: rd_word = {16'h0, state_two_q};
            ldscd_pkg::ADDR_SHIFT: rd_word = {16'h0, shift_q};
            ldscd_pkg::ADDR_MASK: rd_word = {16'h0, mask_q};
            ldscd_pkg::ADDR_LAST_COUNT: rd_word = {27'h0, last_cnt_q};
            ldscd_pkg::ADDR_RUN: rd_word = {30'h0, res14, running_q};
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= ldscd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? ldscd_pkg::RESP_OKAY : ldscd_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

// ---- hw/ldscd_pkg.sv ----
// package of the led driver serial command decoder: constants, commands, carriers
// assumes a 50 MHz system clock and a 32-bit axi4-lite register bus
package ldscd_pkg;

    localparam int CHANNELS = 16;
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

    // pwm periods: full-scale on-time n gives duty n/period
    localparam logic [15:0] PERIOD_16 = 16'hFFFF;
    localparam logic [15:0] PERIOD_14 = 16'h3FFF;
    localparam logic [15:0] MASK_14 = 16'h3FFF;

    // state word one: resolution select (0 = 16-bit, the reset choice)
    localparam int S1_RES14_BIT = 0;
    localparam logic [15:0] STATE_ONE_RST = 16'h0000;
    // state word two fields
    localparam int S2_SERIAL_DATA_OUT_OPT_BIT = 0;
    localparam int S2_DETECT_BIT = 1;
    localparam int S2_ONESHOT_BIT = 2;
    localparam logic [15:0] STATE_TWO_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'hFFFF;
    localparam logic [15:0] GRAY_RST = 16'h0000;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_STATE_ONE = 8'h10;
    localparam logic [7:0] ADDR_STATE_TWO = 8'h14;
    localparam logic [7:0] ADDR_SHIFT = 8'h18;
    localparam logic [7:0] ADDR_MASK = 8'h1C;
    localparam logic [7:0] ADDR_LAST_COUNT = 8'h20;
    localparam logic [7:0] ADDR_RUN = 8'h24;

    localparam int CTRL_BLANK_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // interrupt event bits
    localparam int IRQ_W = 5;
    localparam int EV_WORD = 0;
    localparam int EV_START = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_IGNORED = 3;
    localparam int EV_PERIOD = 4;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 5'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_LOAD_FIRST_STAGE,
        CMD_LATCH_AND_START,
        CMD_LOAD_ON_OFF_MASK,
        CMD_MANUAL_FAULT_CHECK,
        CMD_COUNTER_RESET,
        CMD_STATE_WORD_ONE,
        CMD_STATE_WORD_TWO
    } ldscd_cmd_e;

    // synchronised serial pins
    typedef struct packed {
        logic sck;
        logic serial_data_in;
        logic transfer_command_line;
        logic pwm_clk;
    } ldscd_pins_s;

    typedef struct packed {
        logic [15:3] unused;
        logic oneshot;
        logic detect;
        logic serial_data_out_opt;
    } ldscd_state_two_s;

endpackage

// ---- tb/ldscd_asserts.sv ----
// register-bus handshake checker on the ports of ldscd_top
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/100ps
module ldscd_asserts (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////////////////////
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule

// ---- tb/ldscd_host.sv ----
// host controller model driving serial data, serial clock and transfer line
// assumes the decoder samples these pins with i_ref_clk, so levels last 3 clocks
`timescale 1ns/100ps
module ldscd_host (
    // clock
    input wire logic i_ref_clk,
    // serial pins toward the decoder
    output logic o_sin,
    output logic o_sck,
    output logic o_transfer_command_line,
    input wire logic i_serial_data_out
);
    logic [15:0] seen_q;
    initial begin
        o_sin = 1'b0;
        o_sck = 1'b0;
        o_transfer_command_line = 1'b0;
    end
    task automatic half();
        repeat (3) @(posedge i_ref_clk);
    endtask
    // shift nb bits of w, then give cnt pulses with the transfer line high
    task automatic cmd(input logic [15:0] w, input int nb, input int cnt);
        for (int i = nb - 1; i >= 0; i--) begin
            o_sin <= w[i];
            half();
            seen_q = {seen_q[14:0], i_serial_data_out};
            o_sck <= 1'b1;
            half();
            o_sck <= 1'b0;
        end
        // released data line flips so a stale level is never mistaken for data
        o_sin <= ~o_sin;
        half();
        o_transfer_command_line <= 1'b1;
        half();
        for (int i = 0; i < cnt; i++) begin
            o_sck <= 1'b1;
            half();
            o_sck <= 1'b0;
            half();
        end
        o_transfer_command_line <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
    endtask
endmodule

// ---- tb/ldscd_tb_top.sv ----
// self-checking bench of ldscd_top: serial commands through the host model, registers over axi
// assumes 50 MHz reference clock and a free 160 ns grayscale clock
`timescale 1ns/100ps
module ldscd_tb_top;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_grayscale_reference_clock = 1'b0;
    logic i_serial_data_in, i_serial_clock, i_transfer_command_line, o_serial_data_out, o_irq;
    logic [15:0] i_open_load_detect = 16'h0000, i_shorted_load_detect = 16'h0000, o_channel_on;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errors = 0, cmp_count = 0;
    int ign[2] = '{17, 5};
    int cnt_t[6] = '{7, 8, 13, 14, 15, 16};
    logic [15:0] wd_t[6] = '{16'h1234, 16'hFFFF, 16'h0001, 16'h0000, 16'h0004, 16'h0000};
    always #10 i_ref_clk = ~i_ref_clk;
    always begin
        #37;
        forever #80 i_grayscale_reference_clock = ~i_grayscale_reference_clock;
    end
    ldscd_top ldscd_top_i (.i_ref_clk, .i_reset, .i_serial_data_in, .i_serial_clock,
        .i_transfer_command_line, .i_grayscale_reference_clock, .o_serial_data_out,
        .i_open_load_detect, .i_shorted_load_detect, .o_channel_on, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .o_irq);
    ldscd_host ldscd_host_i (.i_ref_clk, .o_sin(i_serial_data_in), .o_sck(i_serial_clock),
        .o_transfer_command_line(i_transfer_command_line), .i_serial_data_out(o_serial_data_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, ldscd_pkg::RESP_OKAY});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(n, d & m, e);
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (4) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        rdc("mask", ldscd_pkg::ADDR_MASK, 32'h0000_FFFF, 32'hFFFF_FFFF);
        rdc("state1", ldscd_pkg::ADDR_STATE_ONE, 32'h0, 32'hFFFF_FFFF);
        ldscd_host_i.cmd(16'hA5C3, 16, 0);
        rdc("shift", ldscd_pkg::ADDR_SHIFT, 32'h0000_A5C3, 32'hFFFF_FFFF);
        ldscd_host_i.cmd(16'h3C96, 16, 1);
        chk("serial_data_out", {16'h0, ldscd_host_i.seen_q}, 32'h0000_A5C3);
        rdc("shift", ldscd_pkg::ADDR_SHIFT, 32'h0000_3C96, 32'hFFFF_FFFF);
        wr(ldscd_pkg::ADDR_IRQ_ENABLE, 32'h0000_0008);
        foreach (ign[k]) begin
            ldscd_host_i.cmd(16'h0, 0, ign[k]);
            rdc("count", ldscd_pkg::ADDR_LAST_COUNT, ign[k], 32'hFFFF_FFFF);
            rdc("shift", ldscd_pkg::ADDR_SHIFT, 32'h0000_3C96, 32'hFFFF_FFFF);
            chk("irq", {31'h0, o_irq}, 32'h1);
            wr(ldscd_pkg::ADDR_IRQ_CLEAR, 32'h0000_0008);
            @(posedge i_ref_clk);
            chk("irq", {31'h0, o_irq}, 32'h0);
        end
        foreach (cnt_t[k]) begin
            ldscd_host_i.cmd(wd_t[k], 16, cnt_t[k]);
            rdc("word", (k < 2) ? ldscd_pkg::ADDR_MASK : (k < 4) ? ldscd_pkg::ADDR_STATE_ONE
                : ldscd_pkg::ADDR_STATE_TWO, {16'h0, wd_t[k]}, 32'hFFFF_FFFF);
            if (k == 2) rdc("mode", ldscd_pkg::ADDR_RUN, 32'h2, 32'h2);
        end
        i_open_load_detect <= 16'h0081;
        ldscd_host_i.cmd(16'h1111, 16, 9);
        ldscd_host_i.cmd(16'h0, 1, 10);
        rdc("shift", ldscd_pkg::ADDR_SHIFT, 32'h0000_2222, 32'hFFFF_FFFF);
        ldscd_host_i.cmd(16'h0002, 16, 15);
        ldscd_host_i.cmd(16'h0, 0, 9);
        ldscd_host_i.cmd(16'h0, 1, 0);
        rdc("shift", ldscd_pkg::ADDR_SHIFT, 32'h0000_0081, 32'hFFFF_FFFF);
        ldscd_host_i.cmd(16'h0, 16, 16);
        for (int c = 15; c >= 0; c--) ldscd_host_i.cmd(16'(c * 4), 16, 0);
        for (int k = 0; k < 2; k++) begin
            ldscd_host_i.cmd(16'h0, 0, 2 + k);
            for (int t = 0; t < 100 && o_channel_on === 16'h0; t++) @(posedge i_ref_clk);
            repeat (9) @(posedge i_grayscale_reference_clock);
            repeat (2) @(posedge i_ref_clk);
            chk("pwm", {16'h0, o_channel_on}, 32'h0000_FFF8);
            rdc("run", ldscd_pkg::ADDR_RUN, 32'h1, 32'h1);
            ldscd_host_i.cmd(16'h0, 0, 11 + k);
            chk("pwm", {16'h0, o_channel_on}, 32'h0);
            rdc("run", ldscd_pkg::ADDR_RUN, 32'h0, 32'h1);
        end
        rd(8'h30, d, r);
        chk("rresp", {30'h0, r}, {30'h0, ldscd_pkg::RESP_SLVERR});
        chk("rdata", d, 32'h0);
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        errors++;
        end_sim();
    end
endmodule
bind ldscd_top ldscd_asserts ldscd_asserts_i (.i_ref_clk, .i_reset, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
